// ---- lowside_switch_control_spi.v ----
// six-channel low-side switch control with spi and parallel inputs
`timescale 1ns/1ps
`include "lowside_defines.vh"
// How it works
// - hex mode, enable low: outputs 0..2 are parallel input OR command bit.
// - hex mode: outputs 3..5 follow command bits 3..5 only.
// - dual mode: outputs 0,4,5 on by par_in_0 or all command bits 0,4,5.
// - dual mode: outputs 1,2,3 on by par_in_1 or all command bits 1,2,3.
// - mode input intermediate longer than 10 us selects dual mode.
// - hex, enable high, bit 7 clear: 3..5 off, 0..2 parallel only.
// - dual, enable high, bit 7 clear: groups follow parallel inputs, no sleep.
// - enable high and bit 7 set: all off, inputs ignored, spi reset.
// - sleep entry clears spi registers and faults, stops fault detection.
// - power-up or wake from sleep runs 40 us dead time, outputs off.
// - enable asserted outside sleep applies no dead time.
// - short beyond filter time turns output off for retry time, then retries.
// - off output below threshold for filter time flags open load.
// - short or open load latched per output and reported on spi.
// - in sleep the open-load pull-down sources are disabled.
// - sample data on rising clock, update output on falling clock.
// - chip select falling drives output word bit 7 at once.
// - 8-bit shift register, first input bit emerges after eight falling edges.
// - chip select high: serial output released, clock and data ignored.
// - chip select rising loads shift register into command word.
// - chip select rising clears latched faults; persistent ones re-latch.
// - overvoltage indication holds all outputs off while active.
// - filter time 50 us, retry-off time 4.1 ms.
module lowside_switch_control_spi #(
   parameter MODE_CYC = (`MODE_TIME_NS * `CLK_MHZ + 999) / 1000,
   parameter WAKE_CYC = (`WAKE_TIME_NS * `CLK_MHZ + 999) / 1000,
   parameter FILT_CYC = (`FILT_TIME_NS * `CLK_MHZ + 999) / 1000,
   parameter RETRY_CYC = (`RETRY_TIME_NS * `CLK_MHZ + 999) / 1000,
   parameter CNT_W = 20
) (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire par_in_0,
   input wire par_in_1,
   input wire par_in_2_mode_select,
   input wire mode_mid_level,
   input wire enable_n,
   input wire battery_sense,
   input wire [5:0] drain_high,
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_mosi,
   output reg spi_miso,
   output wire spi_miso_oe_n,
   output wire [5:0] switch_out,
   output wire pulldown_en,
   output wire sleep_state,
   output wire dual_mode
);
// ==========================================
// input synchronisers
wire [9:0] raw_in = {drain_high, battery_sense, enable_n, mode_mid_level, par_in_2_mode_select};
wire [9:0] syn_in;
wire p0_s, p1_s, sck_s, cs_s, mosi_s;
genvar gi;
generate
   for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
      sync2 u_sync (
         .clk(clk),
         .srst(srst),
         .ce(ce),
         .d(raw_in[gi]),
         .q(syn_in[gi])
      );
   end
endgenerate
sync2 u_s_p0 (.clk(clk), .srst(srst), .ce(ce), .d(par_in_0), .q(p0_s));
sync2 u_s_p1 (.clk(clk), .srst(srst), .ce(ce), .d(par_in_1), .q(p1_s));
sync2 u_s_sck (.clk(clk), .srst(srst), .ce(ce), .d(spi_sclk), .q(sck_s));
sync2 u_s_mosi (.clk(clk), .srst(srst), .ce(ce), .d(spi_mosi), .q(mosi_s));
sync2 u_s_cs (.clk(clk), .srst(srst), .ce(ce), .d(~spi_cs_n), .q(cs_s));
wire p2_s = syn_in[0];
wire mid_s = syn_in[1];
wire en_n_s = syn_in[2];
wire ov_s = syn_in[3];
wire [5:0] drain_s = syn_in[9:4];

// ==========================================
// edge detection
reg sck_d_r;
reg cs_d_r;
reg en_n_d_r;
always @(posedge clk) begin
   if (srst) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b0;
      en_n_d_r <= 1'b0;
   end else if (ce) begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
      en_n_d_r <= en_n_s;
   end
end
wire sck_rise = sck_s & ~sck_d_r;
wire sck_fall = ~sck_s & sck_d_r;
wire cs_fall_n = cs_s & ~cs_d_r;
wire cs_rise_n = ~cs_s & cs_d_r;
wire en_assert = ~en_n_s & en_n_d_r;

// ==========================================
// sleep and wake control
reg [`WORD_W-1:0] cmd_r;
reg sleep_r;
reg wake_act_r;
reg [CNT_W-1:0] wake_cnt_r;
// sleep when enable high and bit 7
wire sleep_req = en_n_s & cmd_r[`CMD_SLEEP_BIT];
always @(posedge clk) begin
   if (srst) begin
      sleep_r <= 1'b0;
      wake_act_r <= 1'b1;
      wake_cnt_r <= {CNT_W{1'b0}};
   end else if (ce) begin
      if (sleep_req)
         sleep_r <= 1'b1;
      else if (en_assert)
         sleep_r <= 1'b0;
      if (en_assert && sleep_r) begin
         wake_act_r <= 1'b1;
         wake_cnt_r <= {CNT_W{1'b0}};
      end else if (wake_act_r) begin
         if (wake_cnt_r == WAKE_CYC[CNT_W-1:0] - 1'b1)
            wake_act_r <= 1'b0;
         wake_cnt_r <= wake_cnt_r + 1'b1;
      end
   end
end
assign sleep_state = sleep_r;
assign pulldown_en = ~sleep_r;

// ==========================================
// mode select filter
reg dual_r;
reg [CNT_W-1:0] mode_cnt_r;
always @(posedge clk) begin
   if (srst) begin
      dual_r <= 1'b0;
      mode_cnt_r <= {CNT_W{1'b0}};
   end else if (ce) begin
      if (!mid_s) begin
         mode_cnt_r <= {CNT_W{1'b0}};
         dual_r <= 1'b0;
      end else if (mode_cnt_r == MODE_CYC[CNT_W-1:0]) begin
         dual_r <= 1'b1;
      end else begin
         mode_cnt_r <= mode_cnt_r + 1'b1;
      end
   end
end
assign dual_mode = dual_r;

// ==========================================
// spi shift port
reg [`WORD_W-1:0] shift_r;
reg [`BIT_CNT_W-1:0] bit_cnt_r;
wire [5:0] fault_bits;
wire [`WORD_W-1:0] out_word = {2'h0, fault_bits};
wire spi_rst = sleep_r | sleep_req;
always @(posedge clk) begin
   if (srst) begin
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      bit_cnt_r <= {`BIT_CNT_W{1'b0}};
      spi_miso <= 1'b0;
   end else if (ce) begin
      if (spi_rst) begin
         shift_r <= 8'h00;
         cmd_r <= 8'h00;
         bit_cnt_r <= {`BIT_CNT_W{1'b0}};
         spi_miso <= 1'b0;
      // load word and drive bit 7
      end else if (cs_fall_n) begin
         shift_r <= out_word;
         spi_miso <= out_word[`WORD_W-1];
         bit_cnt_r <= {`BIT_CNT_W{1'b0}};
      end else if (cs_rise_n) begin
         cmd_r <= shift_r;
      end else if (cs_s) begin
         if (sck_rise) begin
            shift_r <= {shift_r[`WORD_W-2:0], mosi_s};
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end else if (sck_fall) begin
            spi_miso <= shift_r[`WORD_W-1];
         end
      end
   end
end
assign spi_miso_oe_n = ~cs_s | spi_rst;

// ==========================================
// output decision
reg [5:0] cmd_on;
wire spi_ok = ~en_n_s;
wire grp_a = p0_s | (spi_ok & cmd_r[0] & cmd_r[4] & cmd_r[5]);
wire grp_b = p1_s | (spi_ok & cmd_r[1] & cmd_r[2] & cmd_r[3]);
always @* begin
   cmd_on = 6'h00;
   if (sleep_r || sleep_req || wake_act_r || ov_s) begin
      cmd_on = 6'h00;
   end else if (dual_r) begin
      cmd_on = {grp_a, grp_a, grp_b, grp_b, grp_b, grp_a};
   end else begin
      cmd_on[0] = p0_s | (spi_ok & cmd_r[0]);
      cmd_on[1] = p1_s | (spi_ok & cmd_r[1]);
      cmd_on[2] = p2_s | (spi_ok & cmd_r[2]);
      cmd_on[5:3] = spi_ok ? cmd_r[5:3] : 3'h0;
   end
end

// ==========================================
// fault channels
wire det_en = ~sleep_r & ~sleep_req;
generate
   for (gi = 0; gi < `NUM_OUT; gi = gi + 1) begin : g_fault
      fault_chan #(
         .FILT_CYC(FILT_CYC),
         .RETRY_CYC(RETRY_CYC),
         .CNT_W(CNT_W)
      ) u_fault (
         .clk(clk),
         .srst(srst),
         .ce(ce),
         .cmd_on(cmd_on[gi]),
         .detect_en(det_en),
         .drain_high(drain_s[gi]),
         .fault_clr(cs_rise_n),
         .drive_on(switch_out[gi]),
         .fault_r(fault_bits[gi])
      );
   end
endgenerate
endmodule // lowside_switch_control_spi

// ---- lowside_defines.vh ----
// constants for the low-side switch control block
`ifndef LOWSIDE_DEFINES_VH
`define LOWSIDE_DEFINES_VH
// clock rate in MHz
`define CLK_MHZ 200
// mode filter least time in ns
`define MODE_TIME_NS 10000
// wake-up dead time in ns
`define WAKE_TIME_NS 40000
// fault filter time in ns
`define FILT_TIME_NS 50000
// retry-off time in ns
`define RETRY_TIME_NS 4100000
// command word fields
`define CMD_SLEEP_BIT 7
`define WORD_W 8
`define NUM_OUT 6
`define BIT_CNT_W 3
`define BIT_CNT_LAST 3'h7
`endif

// ---- sync2.v ----
// two-flop synchroniser for one external level
`timescale 1ns/1ps
module sync2 (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire d,
   output reg q
);
reg meta_r;
always @(posedge clk) begin
   if (srst) begin
      meta_r <= 1'b0;
      q <= 1'b0;
   end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
   end
end
endmodule // sync2

// ---- fault_chan.v ----
// per-output short and open-load qualification with retry
`timescale 1ns/1ps
`include "lowside_defines.vh"
module fault_chan #(
   parameter FILT_CYC = 10000,
   parameter RETRY_CYC = 820000,
   parameter CNT_W = 20
) (
   input wire clk,
   input wire srst,
   input wire ce,
   input wire cmd_on,
   input wire detect_en,
   input wire drain_high,
   input wire fault_clr,
   output wire drive_on,
   output reg fault_r
);
reg [CNT_W-1:0] filt_r;
reg [CNT_W-1:0] retry_r;
reg retry_act_r;
wire short_cond = cmd_on & ~retry_act_r & drain_high;
wire open_cond = ~cmd_on & ~drain_high;
wire cond = detect_en & (short_cond | open_cond);
wire qual = cond & (filt_r == FILT_CYC[CNT_W-1:0] - 1'b1);
assign drive_on = cmd_on & ~retry_act_r;
always @(posedge clk) begin
   if (srst) begin
      filt_r <= {CNT_W{1'b0}};
      retry_r <= {CNT_W{1'b0}};
      retry_act_r <= 1'b0;
      fault_r <= 1'b0;
   end else if (ce) begin
      if (!cond || qual)
         filt_r <= {CNT_W{1'b0}};
      else
         filt_r <= filt_r + 1'b1;
      if (!detect_en || !cmd_on) begin
         retry_act_r <= 1'b0;
         retry_r <= {CNT_W{1'b0}};
      end else if (qual && short_cond) begin
         retry_act_r <= 1'b1;
         retry_r <= {CNT_W{1'b0}};
      end else if (retry_act_r) begin
         if (retry_r == RETRY_CYC[CNT_W-1:0] - 1'b1)
            retry_act_r <= 1'b0;
         retry_r <= retry_r + 1'b1;
      end
      if (!detect_en)
         fault_r <= 1'b0;
      else if (qual)
         fault_r <= 1'b1;
      else if (fault_clr)
         fault_r <= 1'b0;
   end
end
endmodule // fault_chan

// ---- lowside_switch_control_spi_props.sv ----
// assertion checker for the low-side switch control block
`timescale 1ns/1ps
module lowside_props #(
   parameter WAKE_CYC = 8000
) (
   input wire clk,
   input wire srst,
   input wire mode_mid_level,
   input wire enable_n,
   input wire battery_sense,
   input wire spi_cs_n,
   input wire spi_miso_oe_n,
   input wire [5:0] switch_out,
   input wire pulldown_en,
   input wire sleep_state,
   input wire dual_mode
);
   reg [15:0] wake_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ==========
   // cycles since reset release
   always @(posedge clk) begin
      if (srst) wake_r <= 16'h0000;
      else if (wake_r != 16'hFFFF) wake_r <= wake_r + 16'h0001;
   end
   chk_dead_time: assert property (wake_r < WAKE_CYC |-> switch_out == 6'h00)
      else $error("output on in dead time");
   chk_mode_drop: assert property (!mode_mid_level [*5] |-> !dual_mode)
      else $error("dual mode without mid level");
   chk_ov_off: assert property (battery_sense [*5] |-> switch_out == 6'h00)
      else $error("output on in overvoltage");
   chk_sleep_off: assert property (sleep_state |-> switch_out == 6'h00 && spi_miso_oe_n)
      else $error("output or miso active in sleep");
   chk_sleep_pulldown: assert property (sleep_state [*2] |-> !pulldown_en)
      else $error("pull-down on in sleep");
   chk_sleep_enable: assert property (!enable_n [*5] |-> !sleep_state)
      else $error("sleep with enable low");
   chk_cs_release: assert property (spi_cs_n [*5] |-> spi_miso_oe_n)
      else $error("miso driven with cs high");
   chk_cs_drive: assert property ($fell(spi_cs_n) && !enable_n && !sleep_state |-> ##[1:6] !spi_miso_oe_n)
      else $error("miso not driven after cs fall");
endmodule // lowside_props
bind lowside_switch_control_spi lowside_props #(.WAKE_CYC(WAKE_CYC)) lowside_props_i (.clk(clk), .srst(srst),
   .mode_mid_level(mode_mid_level), .enable_n(enable_n), .battery_sense(battery_sense), .spi_cs_n(spi_cs_n),
   .spi_miso_oe_n(spi_miso_oe_n), .switch_out(switch_out), .pulldown_en(pulldown_en), .sleep_state(sleep_state),
   .dual_mode(dual_mode));

// ---- spi_host.sv ----
// spi master model standing in for the host controller
`timescale 1ns/1ps
module spi_host (
   output reg sclk,
   output reg cs_n,
   output reg mosi,
   input wire miso,
   input wire miso_oe_n
);
   integer k;
   initial {sclk, cs_n, mosi} = 3'b010;
   // ==========
   // frame transfer, msb first
   task xfer(input [15:0] tx, input integer n, output [15:0] rx);
      rx = 16'h0000;
      cs_n = 1'b0;
      for (k = n - 1; k >= 0; k = k - 1) begin
         mosi = tx[k];
         #32 sclk = 1'b1;
         rx[k] = miso_oe_n ? 1'bx : miso;
         #32 sclk = 1'b0;
      end
      #32 cs_n = 1'b1;
      // data line pulled low once released
      mosi = 1'b0;
   endtask
endmodule // spi_host

// ---- tb_lowside_switch_control_spi.sv ----
// self-checking testbench for the low-side switch control block
`timescale 1ns/1ps
module tb_lowside_switch_control_spi;
   localparam WAKE = 40;
   localparam FILT = 50;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg p0 = 1'b0, p1 = 1'b0, p2 = 1'b0, mid = 1'b0, en_n = 1'b0, ov = 1'b0;
   reg [5:0] inj = 6'h00;
   reg [15:0] rx;
   wire sclk, cs_n, mosi, miso, oe_n, pd, slp, dual;
   wire [5:0] sw;
   integer n_fail = 0, checks = 0, i;
   initial forever #2.5 clk = ~clk;
   lowside_switch_control_spi #(.MODE_CYC(20), .WAKE_CYC(WAKE), .FILT_CYC(FILT), .RETRY_CYC(200))
      lowside_switch_control_spi_i (.clk(clk), .srst(srst), .ce(1'b1), .par_in_0(p0), .par_in_1(p1),
      .par_in_2_mode_select(p2), .mode_mid_level(mid), .enable_n(en_n), .battery_sense(ov),
      .drain_high(~sw ^ inj), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
      .spi_miso_oe_n(oe_n), .switch_out(sw), .pulldown_en(pd), .sleep_state(slp), .dual_mode(dual));
   spi_host spi_host_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe_n(oe_n));
   // ==========
   // shared tasks
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task spi(input [7:0] cmd);
      spi_host_i.xfer({8'h00, cmd}, 8, rx);
      cyc(8);
   endtask
   task check(input [15:0] seen, input [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========
   // test sequence
   initial begin
      cyc(16);
      srst = 1'b0;
      p0 = 1'b1;
      cyc(WAKE - 8);
      check(sw, 6'h00);
      cyc(16);
      check(sw, 6'h01);
      $display("test power-up done");
      spi(8'h38);
      for (i = 0; i < 8; i = i + 1) begin
         {p2, p1, p0} = i[2:0];
         cyc(6);
         check(sw, {3'b111, i[2:0]});
      end
      {p2, p1, p0} = 3'b000;
      spi(8'h47);
      check(sw, 6'h07);
      spi(8'h3F);
      {p2, p1, p0} = 3'b101;
      en_n = 1'b1;
      cyc(6);
      check(sw, 6'h05);
      en_n = 1'b0;
      cyc(6);
      check(sw, 6'h3F);
      $display("test hex done");
      {p2, p1, p0} = 3'b000;
      spi(8'h08);
      inj = 6'h18;
      cyc(FILT + 10);
      check(sw, 6'h00);
      inj = 6'h00;
      spi(8'h08);
      check(rx, 16'h0018);
      check(rx[4], 1'b1);
      spi(8'h08);
      check(rx, 16'h0000);
      cyc(200);
      check(sw, 6'h08);
      spi_host_i.xfer(16'hA503, 16, rx);
      cyc(8);
      check(rx, 16'h00A5);
      check(sw, 6'h03);
      $display("test faults done");
      mid = 1'b1;
      cyc(30);
      check(dual, 1'b1);
      spi(8'h31);
      check(sw, 6'h31);
      spi(8'h1F);
      check(sw, 6'h0E);
      spi(8'h00);
      p0 = 1'b1;
      cyc(6);
      check(sw, 6'h31);
      spi(8'h31);
      p0 = 1'b0;
      p1 = 1'b1;
      en_n = 1'b1;
      cyc(6);
      check({slp, sw}, 7'h0E);
      {mid, p1, en_n} = 3'b000;
      cyc(6);
      check(dual, 1'b0);
      $display("test dual done");
      {p2, p1, p0} = 3'b111;
      spi(8'hB8);
      en_n = 1'b1;
      cyc(8);
      check({slp, pd, sw}, 8'h80);
      spi(8'h07);
      check(rx, 16'h00XX);
      en_n = 1'b0;
      cyc(10);
      check(sw, 6'h00);
      cyc(WAKE);
      check({slp, sw}, 7'h07);
      $display("test sleep done");
      ov = 1'b1;
      cyc(6);
      check(sw, 6'h00);
      ov = 1'b0;
      cyc(6);
      check(sw, 6'h07);
      $display("test overvoltage done");
      stop_test;
   end
   initial begin
      #100000;
      n_fail = n_fail + 1;
      stop_test;
   end
endmodule // tb_lowside_switch_control_spi
